// *** verilog/csu_defs.svh ***
// register map, field positions and memory limits of the compare and search unit
`ifndef CSU_DEFS_SVH
`define CSU_DEFS_SVH
// ==========================================================
// register byte offsets
`define CSU_OFS_CTRL 8'h00
`define CSU_OFS_SEL 8'h04
`define CSU_OFS_ADDR 8'h08
`define CSU_OFS_ACC_LO 8'h0c
`define CSU_OFS_ACC_HI 8'h10
`define CSU_OFS_TOGGLE 8'h14
`define CSU_OFS_AUX_LO 8'h18
`define CSU_OFS_AUX_HI 8'h1c
`define CSU_OFS_INDEX 8'h20
`define CSU_OFS_COUNT 8'h24
`define CSU_OFS_HOLD_LO 8'h28
`define CSU_OFS_HOLD_HI 8'h2c
// ==========================================================
// control fields
`define CSU_CTRL_START 0
`define CSU_CTRL_OP_LSB 1
`define CSU_CTRL_SEARCH 3
// toggle register bits
`define CSU_TG_HI 0
`define CSU_TG_LO 1
`define CSU_TG_EQ 2
`define CSU_TG_MATCH 3
`define CSU_TG_PROG 4
`define CSU_TG_EOM 5
`define CSU_TG_BUSY 6
// ==========================================================
// memory and word shape
`define CSU_MEM_TOP 16'hffff
`define CSU_SIGN_BIT 5
`define CSU_FIELD_MAX 4'h8
`define CSU_SEL_RESET 13'h0038
`endif

// *** verilog/csu_pkg.sv ***
// types shared by the compare and search unit
package csu_pkg;
  // ==========================================================
  // compare instruction selection
  typedef enum logic [1:0] {
    alpha_compare_op = 2'b00,
    numeric_compare_op = 2'b01,
    field_shift_compare_op = 2'b10,
    index_compare_op = 2'b11
  } csu_op_t;
  // sequencer states
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_read = 2'b01,
    st_read_hold = 2'b10,
    st_compare = 2'b11
  } csu_state_t;
endpackage

// *** verilog/csu_top.sv ***
// compare and search unit: alphabetic, numeric, field and index compares with memory search
// Functional notes
// - with search off, alphabetic compare runs once after clearing result and match toggles
// - single alphabetic compare sets exactly one of high, low or equal
// - single compare keeps accumulator and holds the fetched word in auxiliary register
// - alphabetic order uses all six bits, so negative zero sorts above positive zero
// - search needs a result toggle enabled, else program error toggle is set
// - search alphabetic or numeric clears match and keeps the result toggles
// - search walks increasing addresses from operand address, stops on first satisfying word
// - search end writes last address to index register, word kept in auxiliary
// - reaching top of memory without match sets end of memory error instead
// - an interrupt during a search ends it
// - numeric compare is algebraic on digits and sign, positive above negative
// - single numeric compare clears toggles then sets high, low or equal
// - field compare uses full character order, second selector ignored
// - field compare needs an enabled result toggle, and clears match first
// - field compare loads operand word to auxiliary, next word to holding register
// - leading 1 to 8 accumulator characters slide one character lower per miss
// - single field compare stops on match or eight tries, or right after the fetch with end of memory error if started at top of memory; counter keeps count
// - field search streams words, holding register moving into auxiliary each time
// - field search match stores leading character address, counter modulo 8
// - field search ends at top of memory with error, or on interrupt
// - index compare uses digits of positions 0 to 2 and all of position 3
// - index compare clears result toggles, sets one, keeps operand and accumulator
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "csu_defs.svh"
module csu_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core memory read port
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [47:0] mem_data,
  // interrupt request and status
  input wire logic intr_req,
  output logic prog_err,
  output logic eom_err,
  output logic busy
);
  csu_pkg::csu_state_t state_reg;
  csu_pkg::csu_op_t op_reg;
  logic search_reg, busy_reg, mem_req_reg;
  logic [15:0] mem_addr_reg, addr_reg, cur_reg;
  logic [12:0] sel_reg;
  logic [47:0] acc_reg, aux_reg, hold_reg;
  logic [23:0] idx_reg [0:7];
  logic [3:0] cnt_reg;
  logic [2:0] kofs_reg;
  logic hi_reg, lo_reg, eq_reg, match_reg, prog_reg, eom_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic irq_s1, irq_s2, irq_s3, irq_lvl_reg;
  // ==========================================================
  // comparison functions
  // full six-bit characters over positions lo..hi, most significant first
  function automatic logic [1:0] alpha_cmp(input logic [47:0] a, input logic [47:0] m,
                                           input logic [2:0] lo, input logic [2:0] hi);
    logic [1:0] r;
    r = 2'b00;
    for (int i = 7; i >= 0; i--) begin
      if (r == 2'b00 && i <= int'(hi) && i >= int'(lo)) begin
        if (a[i*6 +: 6] > m[i*6 +: 6]) r = 2'b10;
        else if (a[i*6 +: 6] < m[i*6 +: 6]) r = 2'b01;
      end
    end
    return r;
  endfunction
  // digits only, then the sign of the low character decides the direction
  function automatic logic [1:0] num_cmp(input logic [47:0] a, input logic [47:0] m,
                                         input logic [2:0] lo, input logic [2:0] hi);
    logic [1:0] r;
    logic an, mn;
    r = 2'b00;
    an = a[int'(lo)*6 + `CSU_SIGN_BIT];
    mn = m[int'(lo)*6 + `CSU_SIGN_BIT];
    for (int i = 7; i >= 0; i--) begin
      if (r == 2'b00 && i <= int'(hi) && i >= int'(lo)) begin
        if (a[i*6 +: 4] > m[i*6 +: 4]) r = 2'b10;
        else if (a[i*6 +: 4] < m[i*6 +: 4]) r = 2'b01;
      end
    end
    if (an != mn) r = an ? 2'b01 : 2'b10;
    else if (an) r = {r[0], r[1]};
    return r;
  endfunction
  // leading z accumulator characters against the window k characters into aux:hold
  function automatic logic [1:0] fld_cmp(input logic [47:0] a, input logic [95:0] rq,
                                         input logic [3:0] z, input logic [2:0] k);
    logic [1:0] r;
    r = 2'b00;
    for (int i = 0; i < 8; i++) begin
      if (r == 2'b00 && i < int'(z)) begin
        if (a[(7-i)*6 +: 6] > rq[(15-int'(k)-i)*6 +: 6]) r = 2'b10;
        else if (a[(7-i)*6 +: 6] < rq[(15-int'(k)-i)*6 +: 6]) r = 2'b01;
      end
    end
    return r;
  endfunction
  // ==========================================================
  // decode
  wire acc_ph = psel & penable & pready_reg;
  wire wr_en = acc_ph & pwrite;
  wire start = wr_en & (paddr == `CSU_OFS_CTRL) & pwdata[`CSU_CTRL_START] & ~busy_reg;
  wire [1:0] st_op = pwdata[`CSU_CTRL_OP_LSB +: 2];
  wire st_idx = (st_op == csu_pkg::index_compare_op);
  wire st_fld = (st_op == csu_pkg::field_shift_compare_op);
  wire st_srch = pwdata[`CSU_CTRL_SEARCH] & ~st_idx;
  wire perr = (st_srch | st_fld) & ~(hi_reg | lo_reg | eq_reg);
  wire [2:0] f_lo = sel_reg[2:0];
  wire [2:0] f_hi = sel_reg[5:3];
  wire [3:0] f_cnt = sel_reg[9:6];
  wire [2:0] xsel = sel_reg[12:10];
  wire fld = (op_reg == csu_pkg::field_shift_compare_op);
  wire srch = search_reg;
  wire in_cmp = (state_reg == csu_pkg::st_compare);
  wire at_top = (cur_reg == `CSU_MEM_TOP);
  wire q_top = (cur_reg == `CSU_MEM_TOP - 16'h0001);
  wire k_last = (kofs_reg == 3'h7);
  wire [23:0] x_cur = idx_reg[xsel];
  logic [1:0] res;
  // index compare keeps digits of positions 0..2 and all of position 3
  wire [17:0] x_key = {x_cur[23:18], x_cur[15:12], x_cur[9:6], x_cur[3:0]};
  wire [17:0] m_key = {aux_reg[23:18], aux_reg[15:12], aux_reg[9:6], aux_reg[3:0]};
  always_comb begin
    case (op_reg)
      csu_pkg::alpha_compare_op: res = alpha_cmp(acc_reg, aux_reg, f_lo, f_hi);
      csu_pkg::numeric_compare_op: res = num_cmp(acc_reg, aux_reg, f_lo, f_hi);
      csu_pkg::field_shift_compare_op: res = fld_cmp(acc_reg, {aux_reg, hold_reg}, f_cnt, kofs_reg);
      default: res = {x_key > m_key, x_key < m_key};
    endcase
  end
  wire sat = (res[1] & hi_reg) | (res[0] & lo_reg) | (res == 2'b00 && eq_reg);
  // sequencer events
  wire fin_single = in_cmp & ~fld & ~srch;
  wire hit_match = in_cmp & sat & (srch | fld);
  wire fld_end8 = in_cmp & fld & ~srch & ~sat & k_last;
  wire abort_int = in_cmp & srch & ~sat & irq_lvl_reg;
  wire eom_ev = in_cmp & srch & ~sat & ~irq_lvl_reg & (fld ? (k_last & q_top) : at_top);
  wire eom_rd = (state_reg == csu_pkg::st_read) & mem_ack & fld & at_top;
  wire finish = fin_single | hit_match | fld_end8 | abort_int | eom_ev | eom_rd;
  wire [3:0] cnt_inc = srch ? {1'b0, cnt_reg[2:0] + 3'h1} : cnt_reg + 4'h1;
  // ==========================================================
  // interrupt request synchroniser, level taken once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      irq_s3 <= 1'b0;
      irq_lvl_reg <= 1'b0;
    end else begin
      irq_s1 <= intr_req;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      if (irq_s2 == irq_s3) irq_lvl_reg <= irq_s3;
    end
  end
  // ==========================================================
  // apb slave: one wait state, read data captured with pready
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      `CSU_OFS_CTRL: rd_mux = {28'h0, srch, op_reg, 1'b0};
      `CSU_OFS_SEL: rd_mux = {19'h0, sel_reg};
      `CSU_OFS_ADDR: rd_mux = {16'h0, addr_reg};
      `CSU_OFS_ACC_LO: rd_mux = {8'h0, acc_reg[23:0]};
      `CSU_OFS_ACC_HI: rd_mux = {8'h0, acc_reg[47:24]};
      `CSU_OFS_TOGGLE: rd_mux = {25'h0, busy_reg, eom_reg, prog_reg, match_reg, eq_reg, lo_reg, hi_reg};
      `CSU_OFS_AUX_LO: rd_mux = {8'h0, aux_reg[23:0]};
      `CSU_OFS_AUX_HI: rd_mux = {8'h0, aux_reg[47:24]};
      `CSU_OFS_INDEX: rd_mux = {8'h0, x_cur};
      `CSU_OFS_COUNT: rd_mux = {28'h0, cnt_reg};
      `CSU_OFS_HOLD_LO: rd_mux = {8'h0, hold_reg[23:0]};
      `CSU_OFS_HOLD_HI: rd_mux = {8'h0, hold_reg[47:24]};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg) begin
        prdata_reg <= rd_mux;
        pslverr_reg <= ~rd_hit;
      end
    end
  end
  // ==========================================================
  // operand setup; frozen while busy so a running search sees stable operands
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= `CSU_SEL_RESET;
      addr_reg <= 16'h0;
      acc_reg <= 48'h0;
      op_reg <= csu_pkg::alpha_compare_op;
      search_reg <= 1'b0;
    end else if (wr_en & ~busy_reg) begin
      case (paddr)
        `CSU_OFS_CTRL: begin
          op_reg <= csu_pkg::csu_op_t'(st_op);
          search_reg <= st_srch;
        end
        `CSU_OFS_SEL: sel_reg <= pwdata[12:0];
        `CSU_OFS_ADDR: addr_reg <= pwdata[15:0];
        `CSU_OFS_ACC_LO: acc_reg[23:0] <= pwdata[23:0];
        `CSU_OFS_ACC_HI: acc_reg[47:24] <= pwdata[23:0];
        default: ;
      endcase
    end
  end
  // index registers: software loads the selected one, a search end overwrites it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) idx_reg[i] <= 24'h0;
    end else if (finish & (srch | fld)) begin
      idx_reg[xsel] <= {8'h0, cur_reg};
    end else if (wr_en & ~busy_reg & (paddr == `CSU_OFS_INDEX)) begin
      idx_reg[xsel] <= pwdata[23:0];
    end
  end
  // ==========================================================
  // toggles: software writes first, hardware events after so a set wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
      eq_reg <= 1'b0;
      match_reg <= 1'b0;
      prog_reg <= 1'b0;
      eom_reg <= 1'b0;
    end else begin
      if (wr_en & (paddr == `CSU_OFS_TOGGLE)) begin
        if (~busy_reg) begin
          hi_reg <= pwdata[`CSU_TG_HI];
          lo_reg <= pwdata[`CSU_TG_LO];
          eq_reg <= pwdata[`CSU_TG_EQ];
        end
        if (pwdata[`CSU_TG_MATCH]) match_reg <= 1'b0;
        if (pwdata[`CSU_TG_PROG]) prog_reg <= 1'b0;
        if (pwdata[`CSU_TG_EOM]) eom_reg <= 1'b0;
      end
      if (start & perr) prog_reg <= 1'b1;
      if (start & ~perr) begin
        if (~st_idx) match_reg <= 1'b0;
        if (~st_srch & ~st_fld) begin
          hi_reg <= 1'b0;
          lo_reg <= 1'b0;
          eq_reg <= 1'b0;
        end
      end
      if (fin_single) begin
        hi_reg <= res[1];
        lo_reg <= res[0];
        eq_reg <= (res == 2'b00);
      end
      if (hit_match) match_reg <= 1'b1;
      if (eom_ev | eom_rd) eom_reg <= 1'b1;
    end
  end
  // ==========================================================
  // sequencer: fetch, optional hold fetch, then one compare per clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= csu_pkg::st_idle;
      busy_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= 16'h0;
      cur_reg <= 16'h0;
      aux_reg <= 48'h0;
      hold_reg <= 48'h0;
      kofs_reg <= 3'h0;
      cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        csu_pkg::st_idle: begin
          if (start & ~perr) begin
            state_reg <= csu_pkg::st_read;
            busy_reg <= 1'b1;
            mem_req_reg <= 1'b1;
            mem_addr_reg <= addr_reg;
            cur_reg <= addr_reg;
            kofs_reg <= 3'h0;
            cnt_reg <= 4'h0;
          end
        end
        csu_pkg::st_read: begin
          if (mem_ack) begin
            aux_reg <= mem_data;
            mem_req_reg <= 1'b0;
            if (eom_rd) begin
              state_reg <= csu_pkg::st_idle;
              busy_reg <= 1'b0;
            end else if (fld) begin
              state_reg <= csu_pkg::st_read_hold;
              mem_req_reg <= 1'b1;
              mem_addr_reg <= cur_reg + 16'h0001;
            end else begin
              state_reg <= csu_pkg::st_compare;
            end
          end
        end
        csu_pkg::st_read_hold: begin
          if (mem_ack) begin
            hold_reg <= mem_data;
            mem_req_reg <= 1'b0;
            state_reg <= csu_pkg::st_compare;
          end
        end
        csu_pkg::st_compare: begin
          if (fld) cnt_reg <= cnt_inc;
          if (finish) begin
            state_reg <= csu_pkg::st_idle;
            busy_reg <= 1'b0;
          end else if (fld & k_last) begin
            aux_reg <= hold_reg;
            cur_reg <= cur_reg + 16'h0001;
            kofs_reg <= 3'h0;
            mem_req_reg <= 1'b1;
            mem_addr_reg <= cur_reg + 16'h0002;
            state_reg <= csu_pkg::st_read_hold;
          end else if (fld) begin
            kofs_reg <= kofs_reg + 3'h1;
          end else begin
            cur_reg <= cur_reg + 16'h0001;
            mem_req_reg <= 1'b1;
            mem_addr_reg <= cur_reg + 16'h0001;
            state_reg <= csu_pkg::st_read;
          end
        end
        default: state_reg <= csu_pkg::st_idle;
      endcase
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign mem_req = mem_req_reg;
  assign mem_addr = mem_addr_reg;
  assign prog_err = prog_reg;
  assign eom_err = eom_reg;
  assign busy = busy_reg;
  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_single_fetch;
    state_reg == csu_pkg::st_read && mem_ack && !fld && !srch;
  endsequence
  sequence s_single_done;
    in_cmp ##1 !busy_reg && (hi_reg + lo_reg + eq_reg == 2'd1);
  endsequence
  a_single_clear: assert property (start && !perr && !st_srch && !st_fld |=>
    !hi_reg && !lo_reg && !eq_reg && (st_idx || !match_reg)) else $error("single start left toggles set");
  a_single_result: assert property (s_single_fetch |=> s_single_done)
    else $error("single compare did not finish with one result toggle");
  a_acc_stable: assert property (busy_reg |=> $stable(acc_reg))
    else $error("accumulator changed during compare");
  a_prog_error: assert property (start && perr |=> prog_reg && !busy_reg)
    else $error("missing program error on empty toggle set");
  a_search_keep: assert property (busy_reg && srch |=> $stable({hi_reg, lo_reg, eq_reg}))
    else $error("result toggles moved during search");
  a_match_index: assert property (hit_match |=> match_reg && !busy_reg
    && idx_reg[xsel][15:0] == $past(cur_reg)) else $error("match did not store address");
  a_eom_flag: assert property (eom_ev |=> eom_reg && !match_reg && !busy_reg)
    else $error("end of memory not flagged");
  a_intr_end: assert property (abort_int |=> !busy_reg)
    else $error("interrupt did not end search");
  a_field_eight: assert property (fld_end8 |=> cnt_reg == `CSU_FIELD_MAX && !busy_reg)
    else $error("field compare did not stop after eight");
  a_mem_hold: assert property (mem_req_reg && !mem_ack |=> mem_req_reg && $stable(mem_addr_reg))
    else $error("memory request dropped before ack");
endmodule

// *** tb/csu_mem_model.sv ***
// core memory read port model that answers the unit's word fetches
`timescale 1ns/1ns
module csu_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // read port
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [47:0] mem_data,
  // answer delay in cycles
  input wire logic [3:0] wait_cycles
);
  // ==========================================================
  // storage, filled by the bench; unset words read as fill_word
  logic [47:0] words [int unsigned];
  logic [47:0] fill_word = 48'h0;
  int unsigned read_count = 0;
  logic [3:0] wait_cnt;
  // ==========================================================
  // one read outstanding; data scrambles every cycle outside the ack so stale words never look valid
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_data <= 48'h0;
      wait_cnt <= 4'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data;
      if (mem_req && !mem_ack) begin
        if (wait_cnt >= wait_cycles) begin
          mem_ack <= 1'b1;
          mem_data <= words.exists(mem_addr) ? words[mem_addr] : fill_word;
          wait_cnt <= 4'h0;
          read_count <= read_count + 1;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the compare and search unit with a core memory model
`timescale 1ns/1ns
`include "csu_defs.svh"
module testbench;
  // ==========================================================
  // clock, reset and design signals
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic mem_req;
  logic [15:0] mem_addr;
  logic mem_ack;
  logic [47:0] mem_data;
  logic intr_req = 1'b0;
  logic prog_err;
  logic eom_err;
  logic busy;
  logic [3:0] wait_cycles = 4'h0;
  int num_errors = 0;
  int cmp_count = 0;
  int unsigned n0;
  logic [31:0] rd;
  logic err;
  localparam logic [1:0] op_a = csu_pkg::alpha_compare_op;
  localparam logic [1:0] op_n = csu_pkg::numeric_compare_op;
  localparam logic [1:0] op_f = csu_pkg::field_shift_compare_op;
  localparam logic [1:0] op_x = csu_pkg::index_compare_op;
  localparam logic [47:0] fw = 48'hffffffffffff;
  csu_top i_csu_top (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
    .intr_req(intr_req), .prog_err(prog_err), .eom_err(eom_err), .busy(busy));
  csu_mem_model i_csu_mem_model (.mclk(mclk), .rst_n(rst_n), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_data(mem_data), .wait_cycles(wait_cycles));
  // clock at 20 MHz
  initial begin
    forever #25 mclk = ~mclk;
  end
  // ==========================================================
  // helpers
  function automatic logic [12:0] mks(input logic [2:0] lo, input logic [2:0] hi, input logic [3:0] z,
                                      input logic [2:0] ix);
    return {ix, z, hi, lo};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer: held until pready is sampled high, released only after that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic set_acc(input logic [47:0] w);
    apb(1'b1, `CSU_OFS_ACC_LO, {8'h0, w[23:0]});
    apb(1'b1, `CSU_OFS_ACC_HI, {8'h0, w[47:24]});
  endtask
  // presets result toggles (status bits cleared), starts and waits for the unit to go idle
  task automatic go(input logic [1:0] op, input logic srch, input logic [2:0] en, input logic [15:0] a);
    int n;
    n = 0;
    apb(1'b1, `CSU_OFS_TOGGLE, {26'h0, 3'b111, en});
    apb(1'b1, `CSU_OFS_ADDR, {16'h0, a});
    apb(1'b1, `CSU_OFS_CTRL, {28'h0, srch, op, 1'b1});
    do begin
      @(posedge mclk);
      n++;
    end while (busy !== 1'b0 && n < 3000);
    if (n >= 3000) num_errors++;
  endtask
  // single compare with all result toggles preset; exactly one must remain
  task automatic single(input logic [1:0] op, input logic [12:0] sel, input logic [47:0] acc,
                        input logic [47:0] mem, input logic [2:0] exp);
    i_csu_mem_model.words[16'h40] = mem;
    apb(1'b1, `CSU_OFS_SEL, {19'h0, sel});
    set_acc(acc);
    go(op, 1'b0, 3'b111, 16'h0040);
    rchk(`CSU_OFS_TOGGLE, {29'h0, exp});
    rchk(`CSU_OFS_AUX_LO, {8'h0, mem[23:0]});
    rchk(`CSU_OFS_AUX_HI, {8'h0, mem[47:24]});
    rchk(`CSU_OFS_ACC_LO, {8'h0, acc[23:0]});
    rchk(`CSU_OFS_ACC_HI, {8'h0, acc[47:24]});
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d errors=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog sized well above the longest search below
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`CSU_OFS_TOGGLE, 32'h0);
    rchk(`CSU_OFS_SEL, 32'h38);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // single alphabetic and numeric compares, awkward sign and zone cases included
    single(op_a, mks(0, 7, 0, 0), 48'h2, 48'h1, 3'b001);
    single(op_a, mks(0, 7, 0, 0), 48'h1, 48'h2, 3'b010);
    single(op_a, mks(0, 7, 0, 0), 48'h5, 48'h5, 3'b100);
    single(op_a, mks(0, 7, 0, 0), 48'h040000000000, 48'h03ffffffffff, 3'b001);
    single(op_n, mks(0, 0, 0, 0), 48'h04, 48'h03, 3'b001);
    single(op_n, mks(0, 0, 0, 0), 48'h05, 48'h26, 3'b001);
    single(op_n, mks(0, 0, 0, 0), 48'h23, 48'h27, 3'b001);
    single(op_n, mks(0, 0, 0, 0), 48'h00, 48'h20, 3'b001);
    single(op_n, mks(0, 0, 0, 0), 48'h27, 48'h23, 3'b010);
    single(op_n, mks(0, 0, 0, 0), 48'h13, 48'h03, 3'b100);
    // index compare: zone bits of the three low characters ignored, all of the fourth counted
    apb(1'b1, `CSU_OFS_SEL, {19'h0, mks(0, 0, 0, 2)});
    apb(1'b1, `CSU_OFS_INDEX, 32'h141083);
    single(op_x, mks(0, 0, 0, 2), 48'h5, 48'habcdef171cb3, 3'b100);
    single(op_x, mks(0, 0, 0, 2), 48'h5, 48'habcdef571cb3, 3'b010);
    // no result toggle enabled before a search or a field compare
    foreach (rd[i]) begin
      if (i < 4) begin
        go(i[1] ? op_f : (i[0] ? op_n : op_a), i != 2, 3'b000, 16'h0070);
        chk({31'h0, prog_err}, 32'h1);
        rchk(`CSU_OFS_TOGGLE, 32'h10);
      end
    end
    // alphabetic search over slow memory, match on the fourth word
    wait_cycles <= 4'h3;
    i_csu_mem_model.words[16'h10] = 48'h1;
    i_csu_mem_model.words[16'h11] = 48'h2;
    i_csu_mem_model.words[16'h12] = 48'h9;
    i_csu_mem_model.words[16'h13] = 48'h5;
    apb(1'b1, `CSU_OFS_SEL, {19'h0, mks(0, 7, 0, 1)});
    set_acc(48'h5);
    n0 = i_csu_mem_model.read_count;
    go(op_a, 1'b1, 3'b100, 16'h0010);
    rchk(`CSU_OFS_TOGGLE, 32'h0c);
    rchk(`CSU_OFS_INDEX, 32'h13);
    rchk(`CSU_OFS_AUX_LO, 32'h5);
    chk(32'(i_csu_mem_model.read_count - n0), 32'd4);
    // numeric search for a word above the accumulator value
    i_csu_mem_model.words[16'h30] = 48'h01;
    i_csu_mem_model.words[16'h31] = 48'h27;
    i_csu_mem_model.words[16'h32] = 48'h05;
    apb(1'b1, `CSU_OFS_SEL, {19'h0, mks(0, 0, 0, 1)});
    set_acc(48'h03);
    go(op_n, 1'b1, 3'b010, 16'h0030);
    rchk(`CSU_OFS_TOGGLE, 32'h0a);
    rchk(`CSU_OFS_INDEX, 32'h32);
    // search from near the top of memory without a hit
    apb(1'b1, `CSU_OFS_SEL, {19'h0, mks(0, 7, 0, 1)});
    set_acc(48'h0);
    go(op_a, 1'b1, 3'b001, 16'hfffd);
    chk({31'h0, eom_err}, 32'h1);
    rchk(`CSU_OFS_TOGGLE, 32'h21);
    rchk(`CSU_OFS_INDEX, 32'hffff);
    // interrupt in mid-search; finishing inside the wait bound shows the search was cut short
    set_acc(48'h5);
    fork
      go(op_a, 1'b1, 3'b100, 16'h0200);
      begin
        repeat (60) @(posedge mclk);
        intr_req <= 1'b1;
      end
    join
    intr_req <= 1'b0;
    rchk(`CSU_OFS_TOGGLE, 32'h04);
    // single field compare: match at the fourth window, second selector set to junk
    i_csu_mem_model.fill_word = fw;
    i_csu_mem_model.words[16'h50] = {18'h3ffff, 6'h11, 6'h22, 18'h3ffff};
    apb(1'b1, `CSU_OFS_SEL, {19'h0, mks(5, 1, 2, 3)});
    set_acc({6'h11, 6'h22, 36'h0});
    go(op_f, 1'b0, 3'b100, 16'h0050);
    rchk(`CSU_OFS_TOGGLE, 32'h0c);
    rchk(`CSU_OFS_COUNT, 32'h4);
    rchk(`CSU_OFS_AUX_HI, 32'hffffd1);
    rchk(`CSU_OFS_HOLD_LO, 32'hffffff);
    rchk(`CSU_OFS_ACC_HI, 32'h462000);
    // single field compare that misses: stops after eight tries
    go(op_f, 1'b0, 3'b100, 16'h0060);
    rchk(`CSU_OFS_TOGGLE, 32'h04);
    rchk(`CSU_OFS_COUNT, 32'h8);
    // field search with the field straddling two words
    i_csu_mem_model.words[16'h62] = {42'h3ffffffffff, 6'h11};
    i_csu_mem_model.words[16'h63] = {6'h22, 42'h3ffffffffff};
    n0 = i_csu_mem_model.read_count;
    go(op_f, 1'b1, 3'b100, 16'h0060);
    rchk(`CSU_OFS_TOGGLE, 32'h0c);
    rchk(`CSU_OFS_INDEX, 32'h62);
    rchk(`CSU_OFS_COUNT, 32'h0);
    rchk(`CSU_OFS_AUX_LO, 32'hffffd1);
    rchk(`CSU_OFS_HOLD_HI, 32'h8bffff);
    chk(32'(i_csu_mem_model.read_count - n0), 32'd4);
    // field search running off the top of memory
    go(op_f, 1'b1, 3'b100, 16'hfffe);
    chk({31'h0, eom_err}, 32'h1);
    print_verdict();
  end
endmodule
